// [fcd_decoder.sv]
// Floppy command decoder: command, execution and result phases of housekeeping, read ID, format and transfer commands
// Overview of operation
// - Sense drive status returns one byte, the selected drive's state, no execution.
// - Seek steps selected drive to target cylinder, no result phase.
// - Read ID captures first good ID field on current cylinder.
// - Read ID returns status bytes zero to two, then cylinder, head, sector, size.
// - Unassigned opcode enters standby and returns one byte 80h.
// - Dump shared slot holds sectors-per-cylinder after a format command.
// - Dump shared slot holds final sector number after a read or write.
// - Perpendicular drive bits go out on perp_drives, never touching drive select outputs.
// - All transfer commands take the same parameters and return the same results.
// - Transfer commands are told apart only by low five opcode bits.
// - With implied seek enabled, seek to command cylinder before transfer.
// - Implied seek needs no extra bytes or host action.
// - Drive busy flag is set while the seek portion runs.
// - Failed implied seek reports error in status zero and failing cylinder.
module fcd_decoder
(
   input  wire  logic               sys_clk,
   input  wire  logic               srst,
   input  wire  logic               cmd_valid,
   input  wire  logic [7:0]         cmd_data,
   output logic                     cmd_ready,
   output logic                     res_valid,
   output logic [7:0]               res_data,
   input  wire  logic               res_pop,
   input  wire  logic [7:0]         drive_state_byte,
   output logic [1:0]               drive_sel,
   output logic                     head_select,
   output logic                     seek_req,
   output logic [7:0]               seek_cyl,
   input  wire  logic               seek_done,
   input  wire  logic               seek_fail,
   input  wire  logic [7:0]         seek_fail_cyl,
   output logic                     id_req,
   input  wire  logic               id_done,
   input  wire  fcd_pkg::fcd_stat_t id_stat,
   input  wire  fcd_pkg::fcd_id_t   id_field,
   output logic                     xfer_req,
   output fcd_pkg::fcd_xfer_t       xfer_cmd,
   input  wire  logic               xfer_done,
   input  wire  fcd_pkg::fcd_stat_t xfer_stat,
   input  wire  fcd_pkg::fcd_id_t   xfer_id,
   output logic [3:0]               drive_busy,
   output logic                     standby,
   output fcd_pkg::fcd_timing_t     timing,
   output logic                     implied_seek_enable,
   output logic [3:0]               perp_drives,
   output logic                     lock_state
);
   import fcd_pkg::*;

   fcd_state_t  state_r, state_nxt;
   fcd_class_t  cls_r, cls_nxt;
   logic [7:0]  opc_r, opc_nxt;
   logic [7:0]  par_r [0:PAR_DEPTH-1];
   logic [7:0]  par_nxt [0:PAR_DEPTH-1];
   logic [3:0]  pcnt_r, pcnt_nxt, pneed_r, pneed_nxt, rcnt_r, rcnt_nxt;
   logic [7:0]  res_r [0:RES_DEPTH-1];
   logic [7:0]  res_nxt [0:RES_DEPTH-1];
   logic [7:0]  pcn_r [0:3];
   logic [7:0]  pcn_nxt [0:3];
   logic [1:0]  sel_r, sel_nxt;
   logic        hds_r, hds_nxt;
   logic        seek_req_r, seek_req_nxt, id_req_r, id_req_nxt, xfer_req_r, xfer_req_nxt;
   logic [7:0]  seek_cyl_r, seek_cyl_nxt;
   logic        standby_r, standby_nxt, lock_r, lock_nxt, last_fmt_r, last_fmt_nxt;
   logic [7:0]  cfg_r, cfg_nxt, precomp_start_track_r, precomp_start_track_nxt, sc_r, sc_nxt, eot_r, eot_nxt;
   logic [5:0]  perp_r, perp_nxt;
   fcd_timing_t timing_r, timing_nxt;
   fcd_class_t  in_cls;

   function automatic fcd_class_t cmd_class(input logic [7:0] op);
      fcd_class_t c;
      c = CL_INVALID;
      if (op == OPC_SPECIFY) c = CL_SPECIFY;
      else if (op == OPC_SENSE) c = CL_SENSE;
      else if (op == OPC_SEEK) c = CL_SEEK;
      else if (op == OPC_DUMP) c = CL_DUMP;
      else if (op == OPC_CONFIG) c = CL_CONFIG;
      else if (op == OPC_PERP) c = CL_PERP;
      else if (op[6:0] == OPC_LOCK) c = CL_LOCK;
      else if (op[4:0] == XOP_READ_ID && !op[7] && !op[5]) c = CL_READ_ID;
      else if (op[4:0] == XOP_FORMAT && !op[7] && !op[5]) c = CL_FORMAT;
      else if (op[4:0] == XOP_READ || op[4:0] == XOP_READ_DEL || op[4:0] == XOP_WRITE
               || op[4:0] == XOP_WRITE_DEL || op[4:0] == XOP_READ_TRK
               || op[4:0] == XOP_VERIFY) c = CL_XFER;
      return c;
   endfunction : cmd_class

   function automatic logic [3:0] param_count(input fcd_class_t c);
      logic [3:0] n;
      n = NPAR_NONE;
      if (c == CL_SENSE || c == CL_PERP || c == CL_READ_ID) n = NPAR_ONE;
      else if (c == CL_SPECIFY || c == CL_SEEK) n = NPAR_TWO;
      else if (c == CL_CONFIG) n = NPAR_CONFIG;
      else if (c == CL_FORMAT) n = NPAR_FORMAT;
      else if (c == CL_XFER) n = NPAR_XFER;
      return n;
   endfunction : param_count

   function automatic logic has_sel(input fcd_class_t c);
      return c == CL_SENSE || c == CL_SEEK || c == CL_READ_ID || c == CL_XFER
             || c == CL_FORMAT;
   endfunction : has_sel

   assign in_cls = cmd_class(cmd_data);

   always_comb
   begin
      state_nxt = state_r;
      cls_nxt = cls_r;
      opc_nxt = opc_r;
      par_nxt = par_r;
      pcnt_nxt = pcnt_r;
      pneed_nxt = pneed_r;
      rcnt_nxt = rcnt_r;
      res_nxt = res_r;
      pcn_nxt = pcn_r;
      sel_nxt = sel_r;
      hds_nxt = hds_r;
      seek_req_nxt = 1'b0;
      id_req_nxt = 1'b0;
      xfer_req_nxt = 1'b0;
      seek_cyl_nxt = seek_cyl_r;
      standby_nxt = standby_r;
      lock_nxt = lock_r;
      last_fmt_nxt = last_fmt_r;
      cfg_nxt = cfg_r;
      precomp_start_track_nxt = precomp_start_track_r;
      sc_nxt = sc_r;
      eot_nxt = eot_r;
      perp_nxt = perp_r;
      timing_nxt = timing_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (cmd_valid)
            begin
               opc_nxt = cmd_data;
               cls_nxt = in_cls;
               pcnt_nxt = NPAR_NONE;
               pneed_nxt = param_count(in_cls);
               standby_nxt = (in_cls == CL_INVALID);
               state_nxt = (param_count(in_cls) == NPAR_NONE) ? ST_DISP : ST_PARAM;
            end
         end
         ST_PARAM:
         begin
            if (cmd_valid)
            begin
               par_nxt[pcnt_r[2:0]] = cmd_data;
               if (pcnt_r == NPAR_NONE && has_sel(cls_r))
               begin
                  sel_nxt = cmd_data[1:0];
                  hds_nxt = cmd_data[2];
               end
               pcnt_nxt = pcnt_r + NPAR_ONE;
               if (pcnt_r + NPAR_ONE == pneed_r)
                  state_nxt = ST_DISP;
            end
         end
         ST_DISP:
         begin
            state_nxt = ST_RESULT;
            rcnt_nxt = NRES_ONE;
            unique case (cls_r)
               CL_SPECIFY:
               begin
                  timing_nxt = {par_r[0], par_r[1]};
                  state_nxt = ST_IDLE;
               end
               CL_SENSE: res_nxt[0] = drive_state_byte;
               CL_SEEK:
               begin
                  seek_req_nxt = 1'b1;
                  seek_cyl_nxt = par_r[PI_CYL];
                  state_nxt = ST_SEEK;
               end
               CL_DUMP:
               begin
                  for (int i = 0; i < 4; i++)
                     res_nxt[i] = pcn_r[i];
                  res_nxt[4] = timing_r[15:8];
                  res_nxt[5] = timing_r[7:0];
                  res_nxt[6] = last_fmt_r ? sc_r : eot_r;
                  res_nxt[7] = {lock_r, 1'b0, perp_r};
                  res_nxt[8] = cfg_r;
                  res_nxt[9] = precomp_start_track_r;
                  rcnt_nxt = NRES_DUMP;
               end
               CL_CONFIG:
               begin
                  cfg_nxt = par_r[PI_CFG];
                  precomp_start_track_nxt = par_r[PI_PRECOMP_START_TRACK];
                  state_nxt = ST_IDLE;
               end
               CL_PERP:
               begin
                  if (par_r[0][PERP_OW_BIT])
                     perp_nxt[5:2] = par_r[0][5:2];
                  perp_nxt[1:0] = par_r[0][1:0];
                  state_nxt = ST_IDLE;
               end
               CL_LOCK:
               begin
                  lock_nxt = opc_r[7];
                  res_nxt[0] = BYTE_ZERO;
                  res_nxt[0][LOCK_RES_BIT] = opc_r[7];
               end
               CL_READ_ID:
               begin
                  id_req_nxt = 1'b1;
                  state_nxt = ST_READ_ID;
               end
               CL_XFER:
               begin
                  last_fmt_nxt = 1'b0;
                  eot_nxt = par_r[PI_EOT];
                  if (cfg_r[CFG_EIS_BIT])
                  begin
                     seek_req_nxt = 1'b1;
                     seek_cyl_nxt = par_r[PI_CYL];
                     state_nxt = ST_SEEK;
                  end
                  else
                  begin
                     xfer_req_nxt = 1'b1;
                     state_nxt = ST_XFER;
                  end
               end
               CL_FORMAT:
               begin
                  last_fmt_nxt = 1'b1;
                  sc_nxt = par_r[PI_FMT_SC];
                  xfer_req_nxt = 1'b1;
                  state_nxt = ST_XFER;
               end
               default: res_nxt[0] = ST0_INVALID;
            endcase
         end
         ST_SEEK:
         begin
            if (seek_fail)
            begin
               pcn_nxt[sel_r] = seek_fail_cyl;
               state_nxt = ST_IDLE;
               if (cls_r == CL_XFER)
               begin
                  res_nxt[0] = ST0_SEEK_FAIL | {5'h00, hds_r, sel_r};
                  res_nxt[1] = BYTE_ZERO;
                  res_nxt[2] = BYTE_ZERO;
                  res_nxt[3] = seek_fail_cyl;
                  res_nxt[4] = par_r[PI_HEAD];
                  res_nxt[5] = par_r[PI_SECT];
                  res_nxt[6] = par_r[PI_SIZE];
                  rcnt_nxt = NRES_ID;
                  state_nxt = ST_RESULT;
               end
            end
            else if (seek_done)
            begin
               pcn_nxt[sel_r] = seek_cyl_r;
               state_nxt = ST_IDLE;
               if (cls_r == CL_XFER)
               begin
                  xfer_req_nxt = 1'b1;
                  state_nxt = ST_XFER;
               end
            end
         end
         ST_READ_ID:
         begin
            if (id_done)
            begin
               {res_nxt[0], res_nxt[1], res_nxt[2]} = id_stat;
               {res_nxt[3], res_nxt[4], res_nxt[5], res_nxt[6]} = id_field;
               rcnt_nxt = NRES_ID;
               state_nxt = ST_RESULT;
            end
         end
         ST_XFER:
         begin
            if (xfer_done)
            begin
               {res_nxt[0], res_nxt[1], res_nxt[2]} = xfer_stat;
               {res_nxt[3], res_nxt[4], res_nxt[5], res_nxt[6]} = xfer_id;
               rcnt_nxt = NRES_ID;
               state_nxt = ST_RESULT;
            end
         end
         ST_RESULT:
         begin
            if (res_pop)
            begin
               for (int i = 0; i < RES_DEPTH - 1; i++)
                  res_nxt[i] = res_r[i + 1];
               res_nxt[RES_DEPTH-1] = BYTE_ZERO;
               rcnt_nxt = rcnt_r - NRES_ONE;
               if (rcnt_r == NRES_ONE)
                  state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_r <= ST_IDLE;
         cls_r <= CL_INVALID;
         opc_r <= BYTE_ZERO;
         par_r <= '{default: BYTE_ZERO};
         pcnt_r <= NPAR_NONE;
         pneed_r <= NPAR_NONE;
         rcnt_r <= NPAR_NONE;
         res_r <= '{default: BYTE_ZERO};
         pcn_r <= '{default: BYTE_ZERO};
         sel_r <= 2'h0;
         hds_r <= 1'b0;
         seek_req_r <= 1'b0;
         id_req_r <= 1'b0;
         xfer_req_r <= 1'b0;
         seek_cyl_r <= BYTE_ZERO;
         standby_r <= 1'b0;
         lock_r <= 1'b0;
         last_fmt_r <= 1'b0;
         cfg_r <= CFG_RST;
         precomp_start_track_r <= PRECOMP_START_TRACK_RST;
         sc_r <= BYTE_ZERO;
         eot_r <= BYTE_ZERO;
         perp_r <= PERP_RST;
         timing_r <= TIMING_RST;
      end
      else
      begin
         state_r <= state_nxt;
         cls_r <= cls_nxt;
         opc_r <= opc_nxt;
         par_r <= par_nxt;
         pcnt_r <= pcnt_nxt;
         pneed_r <= pneed_nxt;
         rcnt_r <= rcnt_nxt;
         res_r <= res_nxt;
         pcn_r <= pcn_nxt;
         sel_r <= sel_nxt;
         hds_r <= hds_nxt;
         seek_req_r <= seek_req_nxt;
         id_req_r <= id_req_nxt;
         xfer_req_r <= xfer_req_nxt;
         seek_cyl_r <= seek_cyl_nxt;
         standby_r <= standby_nxt;
         lock_r <= lock_nxt;
         last_fmt_r <= last_fmt_nxt;
         cfg_r <= cfg_nxt;
         precomp_start_track_r <= precomp_start_track_nxt;
         sc_r <= sc_nxt;
         eot_r <= eot_nxt;
         perp_r <= perp_nxt;
         timing_r <= timing_nxt;
      end
   end

   genvar gd;
   generate
      for (gd = 0; gd < 4; gd++)
      begin : g_busy
         assign drive_busy[gd] = (state_r == ST_SEEK) && (sel_r == gd);
      end
   endgenerate

   assign cmd_ready = (state_r == ST_IDLE) || (state_r == ST_PARAM);
   assign res_valid = (state_r == ST_RESULT);
   assign res_data = res_r[0];
   assign drive_sel = sel_r;
   assign head_select = hds_r;
   assign seek_req = seek_req_r;
   assign seek_cyl = seek_cyl_r;
   assign id_req = id_req_r;
   assign xfer_req = xfer_req_r;
   assign xfer_cmd = {opc_r, par_r[0], par_r[1], par_r[2], par_r[3], par_r[4], par_r[5],
                      par_r[6], par_r[7]};
   assign standby = standby_r;
   assign timing = timing_r;
   assign implied_seek_enable = cfg_r[CFG_EIS_BIT];
   assign perp_drives = perp_r[5:2];
   assign lock_state = lock_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sense_result_a: assert property ((state_r == ST_DISP && cls_r == CL_SENSE) |=>
      res_valid && rcnt_r == NRES_ONE && res_data == $past(drive_state_byte))
      else $error("sense result wrong");
   seek_silent_a: assert property ((state_r == ST_SEEK && cls_r == CL_SEEK && seek_done
      && !seek_fail) |=> state_r == ST_IDLE && !res_valid && pcn_r[sel_r] == seek_cyl_r)
      else $error("seek gave result");
   readid_bytes_a: assert property ((state_r == ST_READ_ID && id_done) |=>
      rcnt_r == NRES_ID && res_data == $past(id_stat.status_byte_zero)
      && res_r[3] == $past(id_field.cyl) && res_r[6] == $past(id_field.size))
      else $error("read id result wrong");
   invalid_reply_a: assert property ((state_r == ST_DISP && cls_r == CL_INVALID) |=>
      res_valid && res_data == ST0_INVALID && standby && rcnt_r == NRES_ONE)
      else $error("invalid code reply wrong");
   dump_format_a: assert property ((state_r == ST_DISP && cls_r == CL_DUMP
      && last_fmt_r) |=> res_r[6] == $past(sc_r) && rcnt_r == NRES_DUMP)
      else $error("dump slot not sector count");
   dump_eot_a: assert property ((state_r == ST_DISP && cls_r == CL_DUMP
      && !last_fmt_r) |=> res_r[6] == $past(eot_r))
      else $error("dump slot not final sector");
   sel_source_a: assert property ($changed(drive_sel) |->
      $past(state_r == ST_PARAM && pcnt_r == NPAR_NONE && has_sel(cls_r)))
      else $error("drive select moved outside selection byte");
   implied_seek_a: assert property ((state_r == ST_DISP && cls_r == CL_XFER
      && implied_seek_enable) |=> seek_req && !xfer_req && seek_cyl == $past(par_r[PI_CYL]))
      else $error("implied seek missing");
   busy_seek_a: assert property ((state_r == ST_SEEK) |-> drive_busy[sel_r]
      && $onehot(drive_busy))
      else $error("busy flag wrong during seek");
   seek_fail_a: assert property ((state_r == ST_SEEK && cls_r == CL_XFER && seek_fail)
      |=> res_data[7:6] == ST0_SEEK_FAIL[7:6] && res_r[3] == $past(seek_fail_cyl)
      && rcnt_r == NRES_ID)
      else $error("seek failure report wrong");
   lock_reply_a: assert property ((state_r == ST_DISP && cls_r == CL_LOCK) |=>
      lock_state == $past(opc_r[7]) && res_data == {3'h0, lock_state, 4'h0})
      else $error("lock reply wrong");

   sense_cov: cover property (state_r == ST_DISP && cls_r == CL_SENSE);
   dump_cov: cover property (state_r == ST_RESULT && rcnt_r == NRES_DUMP && res_pop);
   implied_cov: cover property (state_r == ST_SEEK && cls_r == CL_XFER && seek_done);
   fail_cov: cover property (state_r == ST_SEEK && cls_r == CL_XFER && seek_fail);
endmodule : fcd_decoder

// [fcd_pkg.sv]
// Package: command codes, counts, reset values and carriers of the floppy command decoder
package fcd_pkg;
   localparam logic [7:0]  OPC_SPECIFY    = 8'h03;
   localparam logic [7:0]  OPC_SENSE      = 8'h04;
   localparam logic [7:0]  OPC_SEEK       = 8'h0F;
   localparam logic [7:0]  OPC_DUMP       = 8'h0E;
   localparam logic [7:0]  OPC_CONFIG     = 8'h13;
   localparam logic [7:0]  OPC_PERP       = 8'h12;
   localparam logic [6:0]  OPC_LOCK       = 7'h14;
   localparam logic [4:0]  XOP_READ_ID    = 5'h0A;
   localparam logic [4:0]  XOP_READ       = 5'h06;
   localparam logic [4:0]  XOP_READ_DEL   = 5'h0C;
   localparam logic [4:0]  XOP_WRITE      = 5'h05;
   localparam logic [4:0]  XOP_WRITE_DEL  = 5'h09;
   localparam logic [4:0]  XOP_READ_TRK   = 5'h02;
   localparam logic [4:0]  XOP_VERIFY     = 5'h16;
   localparam logic [4:0]  XOP_FORMAT     = 5'h0D;
   localparam logic [3:0]  NPAR_NONE      = 4'h0;
   localparam logic [3:0]  NPAR_ONE       = 4'h1;
   localparam logic [3:0]  NPAR_TWO       = 4'h2;
   localparam logic [3:0]  NPAR_CONFIG    = 4'h3;
   localparam logic [3:0]  NPAR_FORMAT    = 4'h5;
   localparam logic [3:0]  NPAR_XFER      = 4'h8;
   localparam logic [3:0]  NRES_ONE       = 4'h1;
   localparam logic [3:0]  NRES_ID        = 4'h7;
   localparam logic [3:0]  NRES_DUMP      = 4'hA;
   localparam int          RES_DEPTH      = 10;
   localparam int          PAR_DEPTH      = 8;
   localparam int          PI_SEL         = 0;
   localparam int          PI_CYL         = 1;
   localparam int          PI_HEAD        = 2;
   localparam int          PI_SECT        = 3;
   localparam int          PI_SIZE        = 4;
   localparam int          PI_EOT         = 5;
   localparam int          PI_FMT_SC      = 2;
   localparam int          PI_CFG         = 1;
   localparam int          PI_PRECOMP_START_TRACK      = 2;
   localparam int          LOCK_RES_BIT   = 4;
   localparam int          PERP_OW_BIT    = 7;
   localparam int          CFG_EIS_BIT    = 6;
   localparam logic [7:0]  ST0_INVALID    = 8'h80;
   localparam logic [7:0]  ST0_SEEK_FAIL  = 8'h50;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;
   localparam logic [7:0]  CFG_RST        = 8'h00;
   localparam logic [7:0]  PRECOMP_START_TRACK_RST     = 8'h00;
   localparam logic [5:0]  PERP_RST       = 6'h00;
   localparam logic [15:0] TIMING_RST     = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_PARAM = 3'b001, ST_DISP = 3'b010, ST_SEEK = 3'b011,
      ST_READ_ID = 3'b100, ST_XFER = 3'b101, ST_RESULT = 3'b110
   } fcd_state_t;

   typedef enum logic [3:0] {
      CL_SPECIFY = 4'b0000, CL_SENSE = 4'b0001, CL_SEEK = 4'b0010, CL_DUMP = 4'b0011,
      CL_CONFIG = 4'b0100, CL_PERP = 4'b0101, CL_LOCK = 4'b0110, CL_READ_ID = 4'b0111,
      CL_XFER = 4'b1000, CL_FORMAT = 4'b1001, CL_INVALID = 4'b1010
   } fcd_class_t;

   typedef struct packed {
      logic [7:0] status_byte_zero;
      logic [7:0] status_byte_one;
      logic [7:0] status_byte_two;
   } fcd_stat_t;

   typedef struct packed {
      logic [7:0] cyl;
      logic [7:0] head;
      logic [7:0] sector;
      logic [7:0] size;
   } fcd_id_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] select;
      logic [7:0] cyl;
      logic [7:0] head;
      logic [7:0] sector;
      logic [7:0] size;
      logic [7:0] final_sector_number;
      logic [7:0] gap_len;
      logic [7:0] data_len;
   } fcd_xfer_t;

   typedef struct packed {
      logic [3:0] step_rate_time;
      logic [3:0] head_unload_time;
      logic [6:0] head_load_time;
      logic       non_dma;
   } fcd_timing_t;
endpackage : fcd_pkg

// [fcd_drive_model.sv]
// Drive-side model: answers seek, ID and transfer requests after a short lag
module fcd_drive_model
(
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       seek_req,
   input  wire logic       id_req,
   input  wire logic       xfer_req,
   input  wire logic [1:0] drive_sel,
   input  wire logic       head_select,
   input  wire logic       fail_seek,
   output logic            seek_done,
   output logic            seek_fail,
   output logic [7:0]      seek_fail_cyl,
   output logic            id_done,
   output fcd_pkg::fcd_stat_t id_stat,
   output fcd_pkg::fcd_id_t   id_field,
   output logic            xfer_done,
   output fcd_pkg::fcd_stat_t xfer_stat,
   output fcd_pkg::fcd_id_t   xfer_id,
   output logic [7:0]      drive_state_byte
);
   timeunit 1ns;
   timeprecision 100ps;
   import fcd_pkg::*;
   localparam fcd_id_t ID_RD = {8'h33, 8'h01, 8'h07, 8'h02};
   logic [1:0] kind_r;
   logic [3:0] wait_r;
   logic [7:0] churn_r;
   logic       fire;
   always_ff @(posedge sys_clk)
   begin
      churn_r <= srst ? 8'h5A : churn_r + 8'h3B;
      if (srst || (wait_r == 4'h0))
         kind_r <= 2'd0;
      if (srst)
         wait_r <= 4'h0;
      else if (seek_req || id_req || xfer_req)
      begin
         kind_r <= seek_req ? 2'd1 : (id_req ? 2'd2 : 2'd3);
         wait_r <= 4'h5;
      end
      else if (wait_r != 4'h0)
         wait_r <= wait_r - 4'h1;
   end
   // Values only valid with their done pulse, churning otherwise
   assign fire          = (kind_r != 2'd0) && (wait_r == 4'h1);
   assign seek_done     = fire && (kind_r == 2'd1) && !fail_seek;
   assign seek_fail     = fire && (kind_r == 2'd1) && fail_seek;
   assign seek_fail_cyl = seek_fail ? 8'h2E : churn_r;
   assign id_done       = fire && (kind_r == 2'd2);
   assign id_stat       = id_done ? 24'h010000 : {3{churn_r}};
   assign id_field      = id_done ? ID_RD : {4{churn_r}};
   assign xfer_done     = fire && (kind_r == 2'd3);
   assign xfer_stat     = xfer_done ? 24'h010000 : {3{churn_r}};
   assign xfer_id       = xfer_done ? ID_RD : {4{churn_r}};
   assign drive_state_byte = {5'b00101, head_select, drive_sel};
endmodule : fcd_drive_model

// [fcd_decoder_bench.sv]
// Bench for the floppy command decoder: command sequences against expected result bytes
module fcd_decoder_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import fcd_pkg::*;
   localparam logic [7:0] GOOD [7] = '{8'h01, 8'h00, 8'h00, 8'h33, 8'h01, 8'h07, 8'h02};
   localparam logic [7:0] BAD  [7] = '{8'h51, 8'h00, 8'h00, 8'h2E, 8'h00, 8'h01, 8'h02};
   localparam logic [7:0] XPAR [8] = '{8'h01, 8'h33, 8'h00, 8'h01, 8'h02, 8'h12, 8'h1B, 8'hFF};
   localparam logic [7:0] OPS  [3] = '{8'hE6, 8'h45, 8'h56};
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic        cmd_valid = 1'b0;
   logic [7:0]  cmd_data = 8'h00;
   logic        res_pop = 1'b0;
   logic        fail_seek = 1'b0;
   logic        cmd_ready, res_valid, head_select, seek_req, seek_done, seek_fail;
   logic        id_req, id_done, xfer_req, xfer_done, standby, implied_seek_enable, lock_state;
   logic [7:0]  res_data, drive_state_byte, seek_cyl, seek_fail_cyl;
   logic [1:0]  drive_sel;
   logic [3:0]  drive_busy, perp_drives;
   fcd_stat_t   id_stat, xfer_stat;
   fcd_id_t     id_field, xfer_id;
   fcd_xfer_t   xfer_cmd;
   fcd_timing_t timing;
   int          fail_count = 0;
   int          compares = 0;
   always #5 sys_clk = ~sys_clk;
   fcd_decoder dut (.sys_clk, .srst, .cmd_valid, .cmd_data, .cmd_ready, .res_valid, .res_data,
      .res_pop, .drive_state_byte, .drive_sel, .head_select, .seek_req, .seek_cyl, .seek_done,
      .seek_fail, .seek_fail_cyl, .id_req, .id_done, .id_stat, .id_field, .xfer_req, .xfer_cmd,
      .xfer_done, .xfer_stat, .xfer_id, .drive_busy, .standby, .timing, .implied_seek_enable,
      .perp_drives, .lock_state);
   fcd_drive_model drive (.sys_clk, .srst, .seek_req, .id_req, .xfer_req, .drive_sel,
      .head_select, .fail_seek, .seek_done, .seek_fail, .seek_fail_cyl, .id_done, .id_stat,
      .id_field, .xfer_done, .xfer_stat, .xfer_id, .drive_state_byte);
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] q[$], input int n);
      @(posedge sys_clk);
      foreach (q[i])
      begin
         cmd_valid <= 1'b1;
         cmd_data  <= q[i];
         do @(negedge sys_clk); while (cmd_ready !== 1'b1);
         @(posedge sys_clk);
      end
      cmd_valid <= 1'b0;
      repeat (n + 1) @(negedge sys_clk);
   endtask : send
   task automatic pop(input logic [7:0] exp, input bit chk);
      do @(negedge sys_clk); while (res_valid !== 1'b1);
      if (chk)
         check(res_data, exp);
      @(posedge sys_clk) res_pop <= 1'b1;
      @(posedge sys_clk) res_pop <= 1'b0;
   endtask : pop
   task automatic xfer(input logic [7:0] op, input bit bad);
      fail_seek <= bad;
      send('{op, XPAR[0], XPAR[1], XPAR[2], XPAR[3], XPAR[4], XPAR[5], XPAR[6], XPAR[7]}, 0);
      do @(negedge sys_clk); while (seek_req !== 1'b1);
      check(seek_cyl, 8'h33);
      check(drive_busy, 4'h2);
      for (int i = 0; i < 7; i++)
         pop(bad ? BAD[i] : GOOD[i], 1'b1);
      check({xfer_cmd.opcode, xfer_cmd.data_len}, {op, XPAR[7]});
   endtask : xfer
   task automatic dump(input logic [7:0] slot);
      logic [7:0] exp [10];
      exp = '{8'h00, 8'h2E, 8'h20, 8'h00, 8'hA5, 8'h3C, slot, 8'hBC, 8'h40, 8'h07};
      send('{OPC_DUMP}, 0);
      foreach (exp[i])
         pop(exp[i], 1'b1);
   endtask : dump
   task automatic end_of_test;
      $display("Mismatches %0d, comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_of_test();
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      send('{OPC_SPECIFY, 8'hA5, 8'h3C}, 3);
      check(timing, 16'hA53C);
      send('{OPC_SENSE, 8'h05}, 0);
      pop(8'h2D, 1'b1);
      send('{OPC_SEEK, 8'h02, 8'h20}, 0);
      check(res_valid, 16'h0);
      do @(negedge sys_clk); while (seek_req !== 1'b1);
      check({drive_busy, seek_cyl}, 12'h420);
      repeat (10) @(negedge sys_clk);
      check({drive_busy, res_valid}, 16'h0);
      send('{8'h00}, 0);
      pop(ST0_INVALID, 1'b1);
      check(standby, 16'h1);
      send('{8'h94}, 0);
      pop(8'h10, 1'b1);
      check({standby, lock_state}, 16'h1);
      send('{OPC_PERP, 8'hBC}, 3);
      check({drive_sel, perp_drives}, 16'h2F);
      send('{OPC_CONFIG, 8'h00, 8'h40, 8'h07}, 3);
      check(implied_seek_enable, 16'h1);
      send('{8'h4A, 8'h01}, 0);
      foreach (GOOD[i])
         pop(GOOD[i], 1'b1);
      foreach (OPS[i])
         xfer(OPS[i], 1'b0);
      xfer(8'h06, 1'b1);
      dump(8'h12);
      send('{8'h4D, 8'h01, 8'h02, 8'h09, 8'h54, 8'hE5}, 0);
      repeat (7) pop(8'h00, 1'b0);
      dump(8'h09);
      end_of_test();
   end
endmodule : fcd_decoder_bench
